// File: hdl/tmw_consts.svh
// constants for the 16-bit waveform timer: modes, fixed tops, timing
// assumes inclusion by the timer module only
`ifndef TMW_CONSTS_SVH
`define TMW_CONSTS_SVH
`define TMW_MODE_NORMAL  4'h0
`define TMW_MODE_CTC_A   4'h4
`define TMW_MODE_FAST8   4'h5
`define TMW_MODE_FAST9   4'h6
`define TMW_MODE_FAST10  4'h7
`define TMW_MODE_CTC_CAP 4'hc
`define TMW_MODE_FASTCAP 4'he
`define TMW_MODE_FASTA   4'hf
`define TMW_TOP8         16'h00ff
`define TMW_TOP9         16'h01ff
`define TMW_TOP10        16'h03ff
`define TMW_MAX          16'hffff
`define TMW_ACT_OFF      2'h0
`define TMW_ACT_TOGGLE   2'h1
`define TMW_ACT_CLEAR    2'h2
`define TMW_ACT_SET      2'h3
`define TMW_PRE_STOP     3'h0
`define TMW_PRE_1        3'h1
`define TMW_PRE_8        3'h2
`define TMW_PRE_64       3'h3
`define TMW_PRE_256      3'h4
`define TMW_PRE_1024     3'h5
`define TMW_DIV8_LAST    3'h7
`define TMW_DIV64_LAST   6'h3f
`define TMW_DIV256_LAST  8'hff
`define TMW_DIV1024_LAST 10'h3ff
`define TMW_RST_COUNT    16'h0000
`endif

// File: hdl/tmw_pkg.sv
// types shared by the waveform timer
// assumes tmw_consts.svh is on the include path
package tmw_pkg;
  typedef enum logic [1:0] {
    TMW_KIND_NORMAL = 2'b00,
    TMW_KIND_CTC    = 2'b01,
    TMW_KIND_FAST   = 2'b10,
    TMW_KIND_NONE   = 2'b11
  } tmw_kind_type;

  // one software write strobe with its data
  typedef struct packed {
    logic        wr;
    logic [15:0] data;
  } tmw_write_type;

  // flags raised towards interrupt logic
  typedef struct packed {
    logic overflow;
    logic compare_a;
    logic compare_b;
    logic capture;
  } tmw_flags_type;
endpackage

// File: hdl/tmw_timer.sv
// 16-bit timer/counter: normal, clear-on-compare and fast pwm counting
// assumes software strobes come from logic on CLOCK_I, pins are not used
// as inputs; flag clear strobes come from the interrupt or software side
`timescale 1ns/100ps
`include "tmw_consts.svh"

// Operation
// - mode 0 counts up forever, no clear, wraps 0xffff to zero
// - mode 0 sets overflow flag when count becomes zero; counting never clears it
// - overflow flag clears when its interrupt is serviced
// - modes 4 and 12 clear count on match with compare a or capture
// - ctc top is unbuffered; writing below count runs to 0xffff and wraps
// - ctc sets the flag of the top-defining register each time top reached
// - ctc toggle action inverts output a on every compare match
// - ctc with top below max sets overflow flag when count passes from max to zero
// - modes 5,6,7,14,15 select single-slope fast pwm
// - fast pwm top fixed, capture or compare a; clear on next tick
// - non-inverting sets at match, clears at top-to-zero; inverting opposite
// - action value two gives non-inverted, three inverted pwm
// - fast pwm sets overflow at top plus the top-defining flag
// - compare writes in fixed-top modes zero bits above resolution
// - capture top in fast pwm is unbuffered; low write misses top
// - fast pwm compare a buffered, loaded at top with clear and overflow
// - compare zero gives spike, compare equal top gives constant level
// - toggle action in fast pwm works only on output a in mode 15
// - timer tick is clock divided by 1, 8, 64, 256 or 1024
// - ctc toggle period is twice one plus compare a timer clocks
// - output action affects only the pin, not the counting sequence
// - compare output reaches the pin only while direction selects output
// - comparators continuously match count against each compare register
// - a count write blocks compare matches in the next timer tick
module tmw_timer
  import tmw_pkg::*;
(
  input  wire logic          CLOCK_I,
  input  wire logic          RSTN_I,
  input  wire logic [3:0]    WAVEFORM_MODE_SEL_I,
  input  wire logic [2:0]    PRESCALE_SEL_I,
  input  wire logic [1:0]    OUTPUT_ACTION_SEL_A_I,
  input  wire logic [1:0]    OUTPUT_ACTION_SEL_B_I,
  input  wire logic          PIN_DIRECTION_BIT_A_I,
  input  wire logic          PIN_DIRECTION_BIT_B_I,
  input  wire tmw_write_type COUNT_WRITE_I,
  input  wire tmw_write_type COMPARE_A_WRITE_I,
  input  wire tmw_write_type COMPARE_B_WRITE_I,
  input  wire tmw_write_type CAPTURE_WRITE_I,
  input  wire tmw_flags_type FLAG_CLEAR_I,
  output logic [15:0]        COUNT_VALUE_O,
  output logic [15:0]        COMPARE_VALUE_A_O,
  output tmw_flags_type      FLAGS_O,
  output logic               COMPARE_OUTPUT_A_O,
  output logic               COMPARE_OUTPUT_A_OE_O,
  output logic               COMPARE_OUTPUT_B_O,
  output logic               COMPARE_OUTPUT_B_OE_O
);

  logic [9:0]    div_count;
  logic [9:0]    next_div_count;
  logic          tick;
  logic [15:0]   count_value;
  logic [15:0]   next_count_value;
  logic [15:0]   compare_buf_a;
  logic [15:0]   next_compare_buf_a;
  logic [15:0]   compare_value_a;
  logic [15:0]   next_compare_value_a;
  logic [15:0]   compare_buf_b;
  logic [15:0]   next_compare_buf_b;
  logic [15:0]   compare_value_b;
  logic [15:0]   next_compare_value_b;
  logic [15:0]   capture_top_value;
  logic [15:0]   next_capture_top_value;
  logic          block_match;
  logic          next_block_match;
  tmw_flags_type flags;
  tmw_flags_type next_flags;
  logic [1:0]    compare_output;
  logic [1:0]    next_compare_output;
  logic [1:0]    pin_oe;

  tmw_kind_type  kind;
  logic [15:0]   top;
  logic [15:0]   res_mask;
  logic          at_top;
  logic [1:0]    match;
  logic [1:0]    action [2];
  logic [15:0]   cmp_now [2];
  logic [1:0]    dir_bit;

  // prescaler: free-running divider, tick is a one-cycle enable
  always_comb
  begin
    next_div_count = div_count + 10'h001;
    tick           = 1'b0;
    case (PRESCALE_SEL_I)
      `TMW_PRE_STOP: next_div_count = 10'h000;
      `TMW_PRE_1:    tick = 1'b1;
      `TMW_PRE_8:    tick = (div_count[2:0] == `TMW_DIV8_LAST);
      `TMW_PRE_64:   tick = (div_count[5:0] == `TMW_DIV64_LAST);
      `TMW_PRE_256:  tick = (div_count[7:0] == `TMW_DIV256_LAST);
      `TMW_PRE_1024: tick = (div_count == `TMW_DIV1024_LAST);
      default:       next_div_count = 10'h000;
    endcase
  end

  // mode decode: counting depends on the waveform mode and, in modes 4, 12, 14 and 15, on the top register
  always_comb
  begin
    kind     = TMW_KIND_NONE;
    top      = `TMW_MAX;
    res_mask = `TMW_MAX;
    case (WAVEFORM_MODE_SEL_I)
      `TMW_MODE_NORMAL:  kind = TMW_KIND_NORMAL;
      `TMW_MODE_CTC_A:
      begin
        kind = TMW_KIND_CTC;
        top  = compare_value_a;
      end
      `TMW_MODE_CTC_CAP:
      begin
        kind = TMW_KIND_CTC;
        top  = capture_top_value;
      end
      `TMW_MODE_FAST8:
      begin
        kind     = TMW_KIND_FAST;
        top      = `TMW_TOP8;
        res_mask = `TMW_TOP8;
      end
      `TMW_MODE_FAST9:
      begin
        kind     = TMW_KIND_FAST;
        top      = `TMW_TOP9;
        res_mask = `TMW_TOP9;
      end
      `TMW_MODE_FAST10:
      begin
        kind     = TMW_KIND_FAST;
        top      = `TMW_TOP10;
        res_mask = `TMW_TOP10;
      end
      `TMW_MODE_FASTCAP:
      begin
        kind = TMW_KIND_FAST;
        top  = capture_top_value;
      end
      `TMW_MODE_FASTA:
      begin
        kind = TMW_KIND_FAST;
        top  = compare_value_a;
      end
      default: kind = TMW_KIND_NONE;  // unsupported modes count as normal
    endcase
  end

  // equality only: a top written below the count is passed by, so the
  // counter runs on to max and wraps before it can match
  assign at_top = (count_value == top) && !block_match;

  assign cmp_now[0] = compare_value_a;
  assign cmp_now[1] = compare_value_b;
  assign action[0]  = OUTPUT_ACTION_SEL_A_I;
  assign action[1]  = OUTPUT_ACTION_SEL_B_I;
  assign dir_bit    = {PIN_DIRECTION_BIT_B_I, PIN_DIRECTION_BIT_A_I};

  // per-channel comparator, waveform action and pin gating
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      // comparator masked for one tick after a count write
      assign match[ch] = (count_value == cmp_now[ch])
                         && !block_match;

      always_comb
      begin
        next_compare_output[ch] = compare_output[ch];
        if (tick)
        begin
          if (kind == TMW_KIND_FAST && action[ch] != `TMW_ACT_OFF)
          begin
            // toggle only where compare a defines top; top wins over match
            if (action[ch] == `TMW_ACT_TOGGLE)
            begin
              if (ch == 0 && match[ch] &&
                  WAVEFORM_MODE_SEL_I == `TMW_MODE_FASTA)
                next_compare_output[ch] = !compare_output[ch];
            end
            else if (at_top)
              next_compare_output[ch] =
                (action[ch] == `TMW_ACT_SET);
            else if (match[ch])
              next_compare_output[ch] =
                (action[ch] == `TMW_ACT_CLEAR);
          end
          else if (match[ch])
          begin
            case (action[ch])
              `TMW_ACT_TOGGLE:
                next_compare_output[ch] = !compare_output[ch];
              `TMW_ACT_CLEAR:  next_compare_output[ch] = 1'b0;
              `TMW_ACT_SET:    next_compare_output[ch] = 1'b1;
              default:         next_compare_output[ch] = compare_output[ch];
            endcase
          end
        end
      end

      // override only when an action is chosen, visible only as output
      assign pin_oe[ch]  = dir_bit[ch] &&
                           (action[ch] != `TMW_ACT_OFF);
    end
  endgenerate

  // counter, compare registers and flags
  always_comb
  begin
    next_count_value       = count_value;
    next_compare_buf_a     = compare_buf_a;
    next_compare_buf_b     = compare_buf_b;
    next_compare_value_a   = compare_value_a;
    next_compare_value_b   = compare_value_b;
    next_capture_top_value = capture_top_value;
    next_block_match       = block_match;
    next_flags             = flags;

    // flag clears first so a same-cycle set wins
    if (FLAG_CLEAR_I.overflow)  next_flags.overflow  = 1'b0;
    if (FLAG_CLEAR_I.compare_a) next_flags.compare_a = 1'b0;
    if (FLAG_CLEAR_I.compare_b) next_flags.compare_b = 1'b0;
    if (FLAG_CLEAR_I.capture)   next_flags.capture   = 1'b0;

    if (tick)
    begin
      next_block_match = 1'b0;
      if (kind == TMW_KIND_FAST)
      begin
        if (at_top)
        begin
          next_count_value     = `TMW_RST_COUNT;
          next_flags.overflow  = 1'b1;
          next_compare_value_a = compare_buf_a;
          next_compare_value_b = compare_buf_b;
          if (WAVEFORM_MODE_SEL_I == `TMW_MODE_FASTA)
            next_flags.compare_a = 1'b1;
          if (WAVEFORM_MODE_SEL_I == `TMW_MODE_FASTCAP)
            next_flags.capture = 1'b1;
        end
        else
          next_count_value = count_value + 16'h0001;
      end
      else if (kind == TMW_KIND_CTC && at_top)
      begin
        next_count_value = `TMW_RST_COUNT;
        if (WAVEFORM_MODE_SEL_I == `TMW_MODE_CTC_CAP)
          next_flags.capture = 1'b1;
      end
      else
      begin
        next_count_value = count_value + 16'h0001;
        if (count_value == `TMW_MAX)
          next_flags.overflow = 1'b1;
      end
      if (match[0]) next_flags.compare_a = 1'b1;
      if (match[1]) next_flags.compare_b = 1'b1;
    end

    // software count write wins over counting, blocks matches in the next tick
    if (COUNT_WRITE_I.wr)
    begin
      next_count_value = COUNT_WRITE_I.data;
      next_block_match = 1'b1;
    end

    // fast pwm writes the buffer; other modes write directly
    if (COMPARE_A_WRITE_I.wr)
    begin
      next_compare_buf_a = COMPARE_A_WRITE_I.data & res_mask;
      if (kind != TMW_KIND_FAST)
        next_compare_value_a = COMPARE_A_WRITE_I.data & res_mask;
    end
    if (COMPARE_B_WRITE_I.wr)
    begin
      next_compare_buf_b = COMPARE_B_WRITE_I.data & res_mask;
      if (kind != TMW_KIND_FAST)
        next_compare_value_b = COMPARE_B_WRITE_I.data & res_mask;
    end
    if (CAPTURE_WRITE_I.wr)
      next_capture_top_value = CAPTURE_WRITE_I.data;
  end

  // state registers, outputs registered from next values
  always_ff @(posedge CLOCK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      div_count             <= 10'h000;
      count_value           <= `TMW_RST_COUNT;
      compare_buf_a         <= 16'h0000;
      compare_value_a       <= 16'h0000;
      compare_buf_b         <= 16'h0000;
      compare_value_b       <= 16'h0000;
      capture_top_value     <= 16'h0000;
      block_match           <= 1'b0;
      flags                 <= '0;
      compare_output        <= 2'h0;
      COUNT_VALUE_O         <= 16'h0000;
      COMPARE_VALUE_A_O     <= 16'h0000;
      FLAGS_O               <= '0;
      COMPARE_OUTPUT_A_O    <= 1'b0;
      COMPARE_OUTPUT_A_OE_O <= 1'b0;
      COMPARE_OUTPUT_B_O    <= 1'b0;
      COMPARE_OUTPUT_B_OE_O <= 1'b0;
    end
    else
    begin
      div_count             <= next_div_count;
      count_value           <= next_count_value;
      compare_buf_a         <= next_compare_buf_a;
      compare_value_a       <= next_compare_value_a;
      compare_buf_b         <= next_compare_buf_b;
      compare_value_b       <= next_compare_value_b;
      capture_top_value     <= next_capture_top_value;
      block_match           <= next_block_match;
      flags                 <= next_flags;
      compare_output        <= next_compare_output;
      COUNT_VALUE_O         <= next_count_value;
      COMPARE_VALUE_A_O     <= next_compare_value_a;
      FLAGS_O               <= next_flags;
      COMPARE_OUTPUT_A_O    <= next_compare_output[0];
      COMPARE_OUTPUT_A_OE_O <= pin_oe[0];
      COMPARE_OUTPUT_B_O    <= next_compare_output[1];
      COMPARE_OUTPUT_B_OE_O <= pin_oe[1];
    end
  end

endmodule

// File: sim/tmw_timer_monitor.sv
// port checker for the waveform timer, bound onto the top module
// assumes one clock and a timer tick on every clock at prescale 1
`timescale 1ns/100ps
module tmw_monitor
  import tmw_pkg::*;
(
  input wire logic          CLOCK_I,
  input wire logic          RSTN_I,
  input wire logic [3:0]    WAVEFORM_MODE_SEL_I,
  input wire logic [2:0]    PRESCALE_SEL_I,
  input wire logic [1:0]    OUTPUT_ACTION_SEL_A_I,
  input wire logic          PIN_DIRECTION_BIT_A_I,
  input wire tmw_write_type COUNT_WRITE_I,
  input wire tmw_write_type COMPARE_A_WRITE_I,
  input wire tmw_flags_type FLAG_CLEAR_I,
  input wire logic [15:0]   COUNT_VALUE_O,
  input wire logic [15:0]   COMPARE_VALUE_A_O,
  input wire tmw_flags_type FLAGS_O,
  input wire logic          COMPARE_OUTPUT_A_O,
  input wire logic          COMPARE_OUTPUT_A_OE_O
);
  logic       ok;
  logic [3:0] md;
  logic       top_a;
  logic       pin_drive;
  // steady ticking, no write that could block or move a match
  assign ok = PRESCALE_SEL_I == 3'h1 && !COUNT_WRITE_I.wr
              && !COMPARE_A_WRITE_I.wr;
  assign md = WAVEFORM_MODE_SEL_I;
  assign top_a = COUNT_VALUE_O == COMPARE_VALUE_A_O;
  // pin should be driven: direction output and an action chosen
  assign pin_drive = PIN_DIRECTION_BIT_A_I
    && OUTPUT_ACTION_SEL_A_I != 2'h0;
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RSTN_I);

  a_normal_step: assert property (ok ##1 ok && md == 4'h0
    |=> COUNT_VALUE_O == $past(COUNT_VALUE_O) + 16'h0001)
    else $error("normal count did not step");
  a_normal_wrap: assert property (ok ##1 ok && md == 4'h0
    && COUNT_VALUE_O == 16'hffff |=> FLAGS_O.overflow)
    else $error("no overflow on wrap");
  a_flag_held: assert property (FLAGS_O.overflow
    && !FLAG_CLEAR_I.overflow |=> FLAGS_O.overflow)
    else $error("overflow dropped without clear");
  a_ctc_clear: assert property (ok ##1 ok && md == 4'h4 && top_a
    |=> COUNT_VALUE_O == 16'h0000 && FLAGS_O.compare_a)
    else $error("ctc did not clear at top");
  a_ctc_toggle: assert property (ok ##1 ok && md == 4'h4 && top_a
    && OUTPUT_ACTION_SEL_A_I == 2'h1 |=> $changed(COMPARE_OUTPUT_A_O))
    else $error("ctc output did not toggle");
  a_fixed_top: assert property (ok ##1 ok && md == 4'h5
    && COUNT_VALUE_O == 16'h00ff
    |=> COUNT_VALUE_O == 16'h0000 && FLAGS_O.overflow)
    else $error("fixed top not honoured");
  a_fast_load: assert property (ok ##1 ok && md == 4'hf && top_a
    |=> COUNT_VALUE_O == 16'h0000 && FLAGS_O.overflow
    && FLAGS_O.compare_a)
    else $error("fast top did not clear and flag");
  a_buffer_hold: assert property (md == 4'hf && !top_a
    |=> $stable(COMPARE_VALUE_A_O))
    else $error("buffered compare moved off top");
  a_noninv_top: assert property (ok ##1 ok && md == 4'h5
    && COUNT_VALUE_O == 16'h00ff && OUTPUT_ACTION_SEL_A_I == 2'h2
    |=> !COMPARE_OUTPUT_A_O)
    else $error("non-inverted output not low after top");
  a_pin_enable: assert property (1'b1 |=> COMPARE_OUTPUT_A_OE_O ==
    $past(pin_drive))
    else $error("pin enable does not follow direction");
endmodule

bind tmw_timer tmw_monitor mon_u (.CLOCK_I, .RSTN_I,
  .WAVEFORM_MODE_SEL_I, .PRESCALE_SEL_I, .OUTPUT_ACTION_SEL_A_I,
  .PIN_DIRECTION_BIT_A_I, .COUNT_WRITE_I, .COMPARE_A_WRITE_I,
  .FLAG_CLEAR_I, .COUNT_VALUE_O, .COMPARE_VALUE_A_O, .FLAGS_O,
  .COMPARE_OUTPUT_A_O, .COMPARE_OUTPUT_A_OE_O);

// File: sim/tmw_load_model.sv
// external load on one compare pin, with pull-down and level counters
// assumes pin and enable come from registers on the same clock
`timescale 1ns/100ps
module tmw_load_model (
  input  wire logic   clk_i,
  input  wire logic   pin_i,
  input  wire logic   oe_i,
  input  wire logic   clr_i,
  output logic        level_o,
  output logic [15:0] high_o,
  output logic [15:0] rise_o
);
  logic last;
  // released pin sinks to the pull-down level, never holds its value
  assign level_o = oe_i ? pin_i : 1'b0;
  // counters restart on clear so windows line up with the bench
  always_ff @(posedge clk_i)
  begin
    last <= level_o;
    high_o <= clr_i ? 16'h0000 : high_o + {15'h0000, level_o};
    rise_o <= clr_i ? 16'h0000 : rise_o + {15'h0000, level_o & ~last};
  end
endmodule

// File: sim/tmw_timer_tb.sv
// self-checking bench for the waveform timer driving two pin loads
// assumes the package is compiled first and the monitor is bound in
`timescale 1ns/100ps
module tmw_timer_tb;
  import tmw_pkg::*;
  logic          clk;
  logic          rstn = 1'b0;
  logic          dir_a = 1'b0;
  logic          dir_b = 1'b0;
  logic          clr = 1'b0;
  logic [3:0]    mode = 4'h0;
  logic [2:0]    pre = 3'h0;
  logic [1:0]    act_a = 2'h0;
  logic [1:0]    act_b = 2'h0;
  tmw_write_type cnt_w = '0;
  tmw_write_type cma_w = '0;
  tmw_write_type cmb_w = '0;
  tmw_write_type cap_w = '0;
  tmw_flags_type fclr = '0;
  tmw_flags_type flags;
  logic [15:0]   count, cmpa, high_a, high_b, rise_a;
  logic          oc_a, oe_a, oc_b, oe_b;
  int            fail_count = 0;
  int            checks = 0;
  int            cycles = 0;

  tmw_timer dut_u (.CLOCK_I(clk), .RSTN_I(rstn),
    .WAVEFORM_MODE_SEL_I(mode), .PRESCALE_SEL_I(pre),
    .OUTPUT_ACTION_SEL_A_I(act_a), .OUTPUT_ACTION_SEL_B_I(act_b),
    .PIN_DIRECTION_BIT_A_I(dir_a), .PIN_DIRECTION_BIT_B_I(dir_b),
    .COUNT_WRITE_I(cnt_w), .COMPARE_A_WRITE_I(cma_w),
    .COMPARE_B_WRITE_I(cmb_w), .CAPTURE_WRITE_I(cap_w),
    .FLAG_CLEAR_I(fclr), .COUNT_VALUE_O(count),
    .COMPARE_VALUE_A_O(cmpa), .FLAGS_O(flags),
    .COMPARE_OUTPUT_A_O(oc_a), .COMPARE_OUTPUT_A_OE_O(oe_a),
    .COMPARE_OUTPUT_B_O(oc_b), .COMPARE_OUTPUT_B_OE_O(oe_b));
  tmw_load_model load_a (.clk_i(clk), .pin_i(oc_a), .oe_i(oe_a),
    .clr_i(clr), .level_o(), .high_o(high_a), .rise_o(rise_a));
  tmw_load_model load_b (.clk_i(clk), .pin_i(oc_b), .oe_i(oe_b),
    .clr_i(clr), .level_o(), .high_o(high_b), .rise_o());

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard, well above the longest expected run
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 50000)
    begin
      fail_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic cfg(input logic [3:0] m, input logic [2:0] p,
                     input logic [1:0] a, input logic [1:0] b);
    @(posedge clk);
    mode <= m;
    pre <= p;
    act_a <= a;
    act_b <= b;
    dir_a <= 1'b1;
    dir_b <= 1'b1;
  endtask

  // one-cycle write strobe on the selected 16-bit register
  task automatic put(input int k, input logic [15:0] d);
    @(posedge clk);
    case (k)
      0: cnt_w <= '{1'b1, d};
      1: cma_w <= '{1'b1, d};
      2: cmb_w <= '{1'b1, d};
      default: cap_w <= '{1'b1, d};
    endcase
    @(posedge clk);
    cnt_w.wr <= 1'b0;
    cma_w.wr <= 1'b0;
    cmb_w.wr <= 1'b0;
    cap_w.wr <= 1'b0;
    #1;
  endtask

  task automatic fl_clear();
    @(posedge clk);
    fclr <= '1;
    @(posedge clk);
    fclr <= '0;
    tick(1);
  endtask

  // load statistics over exactly w clocks
  task automatic win(input int w);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    tick(w);
  endtask

  task automatic t_normal();
    cfg(4'h0, 3'h1, 2'h0, 2'h0);
    put(0, 16'hfffd);
    tick(3);
    chk(count, 16'h0000);
    chk(16'(flags.overflow), 16'h0001);
    cfg(4'h0, 3'h0, 2'h0, 2'h0);
    fl_clear();
    chk(16'(flags.overflow), 16'h0000);
  endtask

  // second interval after a change is a full prescaler period
  task automatic t_prescale();
    int div [5] = '{1, 8, 64, 256, 1024};
    logic [15:0] c;
    int n;
    for (int s = 0; s < 5; s++)
    begin
      cfg(4'h0, 3'(s + 1), 2'h0, 2'h0);
      tick(1);
      repeat (2)
      begin
        c = count;
        n = 0;
        while (count === c && n < 2000)
        begin
          tick(1);
          n++;
        end
      end
      chk(16'(n), 16'(div[s]));
    end
  endtask

  task automatic t_ctc();
    int v [2] = '{0, 3};
    fl_clear();
    for (int i = 0; i < 2; i++)
    begin
      cfg(4'h4, 3'h1, 2'h1, 2'h0);
      put(1, 16'(v[i]));
      put(0, 16'hfffe);
      // start mid half-period so the edge count is phase independent
      tick(2);
      win(64);
      chk(rise_a, 16'(32 / (1 + v[i])));
      chk(high_a, 16'h0020);
    end
    chk(16'(flags.overflow), 16'h0001);
    chk(16'(flags.compare_a), 16'h0001);
    @(posedge clk);
    dir_a <= 1'b0;
    win(64);
    chk(high_a, 16'h0000);
    put(3, 16'h0005);
    cfg(4'hc, 3'h1, 2'h0, 2'h0);
    fl_clear();
    tick(20);
    chk(16'(flags.capture), 16'h0001);
    chk(16'(count <= 16'h0005), 16'h0001);
  endtask

  // a count write blocks the next match, also while stopped
  task automatic t_block();
    int n = 0;
    cfg(4'h4, 3'h0, 2'h0, 2'h0);
    put(1, 16'h0005);
    put(0, 16'h0005);
    fl_clear();
    cfg(4'h4, 3'h1, 2'h0, 2'h0);
    while (count === 16'h0005 && n < 8)
    begin
      tick(1);
      n++;
    end
    chk(count, 16'h0006);
    chk(16'(flags.compare_a), 16'h0000);
    put(0, 16'h0005);
    tick(1);
    chk(count, 16'h0006);
    put(0, 16'h0000);
  endtask

  task automatic t_fast();
    logic [3:0] md [9] = '{4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'h6, 4'h7,
                           4'he, 4'hf};
    logic [15:0] cv [9] = '{16'hff40, 16'hff40, 16'hffff, 16'hffff,
                            16'h0, 16'h0, 16'h0, 16'h0040, 16'h0007};
    logic [1:0] ac [9] = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3,
                           2'h2, 2'h1};
    int hi [9] = '{382, 130, 0, 512, 2, 2, 2, 382, 8};
    logic [15:0] top;
    logic [1:0] ab;
    put(3, 16'h00ff);
    for (int i = 0; i < 9; i++)
    begin
      top = md[i] == 4'h6 ? 16'h01ff : md[i] == 4'h7 ? 16'h03ff :
            md[i] == 4'hf ? cv[i] : 16'h00ff;
      ab = ac[i] >= 2'h2 ? ac[i] : 2'h0;
      cfg(md[i], 3'h1, ac[i], ab);
      put(1, cv[i]);
      put(2, cv[i]);
      put(0, 16'h0000);
      tick(2 * (top + 1) + 200);
      chk(cmpa, cv[i] & (md[i] < 4'h8 ? top : 16'hffff));
      fl_clear();
      win(2 * (top + 1));
      chk(high_a, 16'(hi[i]));
      chk(high_b, ab != 2'h0 ? 16'(hi[i]) : 16'h0000);
      chk(16'(flags.compare_b), 16'h0001);
    end
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_normal();
    t_prescale();
    t_ctc();
    t_block();
    t_fast();
    final_report();
  end
endmodule
